// ### src/pressure_bank_pkg.sv
// constants, encodings and timing shared by the register bank modules
package pressure_bank_pkg;

  // ---------------------------------------------------------------
  // byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PART_LOW      = 8'h00;
  localparam logic [7:0] ADDR_PART_HIGH     = 8'h01;
  localparam logic [7:0] ADDR_SERIAL0       = 8'h02;
  localparam logic [7:0] ADDR_SERIAL1       = 8'h03;
  localparam logic [7:0] ADDR_SERIAL2       = 8'h04;
  localparam logic [7:0] ADDR_SERIAL3       = 8'h05;
  localparam logic [7:0] ADDR_MODE          = 8'h06;
  localparam logic [7:0] ADDR_LO_TOP        = 8'h0F;
  localparam logic [7:0] ADDR_HI_BOTTOM     = 8'h10;
  localparam logic [7:0] ADDR_HI_MIDDLE     = 8'h11;
  localparam logic [7:0] ADDR_HI_TOP        = 8'h12;
  localparam logic [7:0] ADDR_QUEUE_SETUP   = 8'h13;
  localparam logic [7:0] ADDR_READY_FLAGS   = 8'h14;
  localparam logic [7:0] ADDR_FILL_FLAGS    = 8'h15;
  localparam logic [7:0] ADDR_EVENT_FLAGS   = 8'h16;
  localparam logic [7:0] ADDR_PRESS_BOTTOM  = 8'h17;
  localparam logic [7:0] ADDR_PRESS_MIDDLE  = 8'h18;
  localparam logic [7:0] ADDR_PRESS_TOP     = 8'h19;
  localparam logic [7:0] ADDR_TEMP_LOW      = 8'h1A;
  localparam logic [7:0] ADDR_TEMP_HIGH     = 8'h1B;
  localparam logic [7:0] ADDR_QPRESS_BOTTOM = 8'h27;
  localparam logic [7:0] ADDR_QPRESS_MIDDLE = 8'h28;
  localparam logic [7:0] ADDR_QPRESS_TOP    = 8'h29;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MODE        = 8'h03;
  localparam logic [7:0] RST_LO_TOP      = 8'h00;
  localparam logic [7:0] RST_HI_BYTE     = 8'hFF;
  localparam logic [7:0] RST_QUEUE_SETUP = 8'h00;
  localparam logic [7:0] RST_READY       = 8'h00;
  localparam logic [7:0] RST_FILL        = 8'h02;
  localparam logic [7:0] RST_EVENT       = 8'h08;
  localparam logic [7:0] RST_RESULT      = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MODE_HP_BIT    = 7;
  localparam int MODE_PATH_HI   = 6;
  localparam int MODE_PATH_LO   = 5;
  localparam int MODE_RUN_BIT   = 4;
  localparam int MODE_SRST_BIT  = 3;
  localparam int MODE_TEMP_BIT  = 1;
  localparam int MODE_PRESS_BIT = 0;
  localparam int READY_TEMP_BIT = 0;
  localparam int READY_PRES_BIT = 1;
  localparam int OVER_TEMP_BIT  = 2;
  localparam int OVER_PRES_BIT  = 3;

  typedef enum logic [1:0] {
    PATH_DIRECT  = 2'b00,
    PATH_QUEUE   = 2'b01,
    PATH_AVERAGE = 2'b10
  } path_t;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int  CLK_KHZ          = 250000;
  localparam real HP_SETTLE_MS     = 0.5;
  localparam int  HP_SETTLE_CYCLES = int'(HP_SETTLE_MS * CLK_KHZ);
  localparam int  SETTLE_W         = 17;

endpackage : pressure_bank_pkg

// ### src/bank_if.sv
// carrier between the register bank and its gate and scheduler
`timescale 1ns/10ps
interface bank_if;
  logic [7:0] addr;
  logic       highPower;
  logic       accessOk;
  logic [7:0] nextAddr;
  logic       runOn;
  logic       tempEn;
  logic       pressEn;
  logic       slotReq;
  logic       slotValid;
  logic       slotIsTemp;

  modport bank  (output addr, highPower, runOn, tempEn, pressEn, slotReq,
                 input  accessOk, nextAddr, slotValid, slotIsTemp);
  modport gate  (input  addr, highPower, output accessOk, nextAddr);
  modport sched (input  runOn, tempEn, pressEn, slotReq,
                 output slotValid, slotIsTemp);
endinterface : bank_if

// ### src/access_gate.sv
// access permission and auto-increment address step
`timescale 1ns/10ps
module access_gate
  import pressure_bank_pkg::*;
(
  bank_if.gate g
);

  function automatic logic [7:0] step_addr(input logic [7:0] a);
    if (a == ADDR_QPRESS_TOP) begin
      step_addr = ADDR_QPRESS_BOTTOM;
    end else begin
      step_addr = a + 8'h01;
    end
  endfunction : step_addr

  always_comb begin
    g.nextAddr = step_addr(g.addr);
    if (g.highPower) begin
      g.accessOk = 1'b1;
    end else if (g.addr == ADDR_MODE || g.addr == ADDR_PART_LOW ||
                 g.addr == ADDR_PART_HIGH || g.addr == ADDR_READY_FLAGS ||
                 g.addr == ADDR_FILL_FLAGS || g.addr == ADDR_EVENT_FLAGS ||
                 (g.addr >= ADDR_PRESS_BOTTOM && g.addr <= ADDR_TEMP_HIGH))
    begin
      g.accessOk = 1'b1;
    end else begin
      g.accessOk = 1'b0;
    end
  end

endmodule : access_gate

// ### src/slot_scheduler.sv
// chooses the kind of each measurement slot from the enables
`timescale 1ns/10ps
module slot_scheduler (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstSyncB,
  // bank side
  bank_if.sched     s
);

  typedef enum logic [1:0] {S_IDLE, S_AFTER_T, S_AFTER_P} slot_state_t;
  slot_state_t stateQ;

  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      stateQ       <= S_IDLE;
      s.slotValid  <= 1'b0;
      s.slotIsTemp <= 1'b0;
    end else if (!s.runOn || !(s.tempEn || s.pressEn)) begin
      stateQ      <= S_IDLE;
      s.slotValid <= 1'b0;
    end else if (s.slotReq) begin
      s.slotValid <= 1'b1;
      case (stateQ)
        // every run opens with temperature, also for pressure only
        S_IDLE: begin
          s.slotIsTemp <= 1'b1;
          stateQ       <= S_AFTER_T;
        end
        S_AFTER_T: begin
          s.slotIsTemp <= !s.pressEn;
          stateQ       <= s.pressEn ? S_AFTER_P : S_AFTER_T;
        end
        default: begin
          s.slotIsTemp <= s.tempEn;
          stateQ       <= s.tempEn ? S_AFTER_T : S_AFTER_P;
        end
      endcase
    end else begin
      s.slotValid <= 1'b0;
    end
  end

endmodule : slot_scheduler

// ### src/pressure_sensor_register_bank.sv
// host-visible register bank of the pressure and temperature sensor
`timescale 1ns/10ps

// Functional notes
// - multi-byte values are little-endian, lowest address holds LSB
// - 16-bit read-only part code at 0x00-0x01, valid after init
// - 32-bit read-only unit serial at 0x02-0x05, LSB first
// - high-power bit set makes every register reachable
// - high power clear: only mode, part code, status, pressure and temperature results reachable
// - path selector 00 direct, 01 queue, 10 moving average
// - run bit one starts measuring, zero stops and goes idle
// - one-shot completion clears the run bit by itself
// - soft reset restores power-on configuration and clears itself
// - low threshold top at 0x0F resets 0; high threshold bytes 0xFF
// - queued pressure output at 0x27-0x29, bytes reset to zero
// - auto-increment wraps inside the queued pressure group
// - ultra-low power pressure reads return only latest value
// - pressure only starts with temperature; both interleave
module pressure_sensor_register_bank
  import pressure_bank_pkg::*;
#(
  parameter logic [15:0]  PART_CODE     = 16'h5AC3, // arbitrary value
  parameter logic [31:0]  UNIT_SERIAL   = 32'h1234_ABCD, // arbitrary value
  parameter int           SETTLE_CYCLES = pressure_bank_pkg::HP_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  // byte register port from the serial transport
  input  wire logic [7:0]                  regAddr,
  input  wire logic [7:0]                  regWrData,
  input  wire logic                        regWrEn,
  input  wire logic                        regRdEn,
  output logic      [7:0]                  regRdData,
  output logic                             regRdValid,
  output logic      [7:0]                  regNextAddr,
  // measurement engine inputs
  input  wire logic                        initDone,
  input  wire logic                        ultraLowPower,
  input  wire logic [23:0]                 pressSample,
  input  wire logic                        pressValid,
  input  wire logic [15:0]                 tempSample,
  input  wire logic                        tempValid,
  input  wire logic [23:0]                 queuedSample,
  input  wire logic                        queuedValid,
  input  wire logic                        oneShotDone,
  input  wire logic [7:0]                  queueFlags,
  input  wire logic [7:0]                  eventFlags,
  input  wire logic                        slotRequest,
  // configuration to the measurement engine
  output logic                             highPower,
  output pressure_bank_pkg::path_t         pathSelect,
  output logic                             runEnable,
  output logic                             temperatureEnable,
  output logic                             pressureEnable,
  output logic      [7:0]                  lowThresholdTop,
  output logic      [23:0]                 highThreshold,
  output logic      [7:0]                  queueSetup,
  output logic                             softResetPulse,
  output logic                             settleBusy,
  output logic                             slotValid,
  output logic                             slotIsTemp
);
  import pressure_bank_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic       rstMetaB;
  logic       rstSyncB;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMetaB <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMetaB <= 1'b1;
      rstSyncB <= rstMetaB;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]          mode_q;
  logic [7:0]          loTop_q;
  logic [23:0]         hiThr_q;
  logic [7:0]          queueSetup_q;
  logic [7:0]          ready_q;
  logic [7:0]          ready_d;
  logic [7:0]          fill_q;
  logic [7:0]          event_q;
  logic [23:0]         pressHeld_q;
  logic [23:0]         pressLatest_q;
  logic [15:0]         temp_q;
  logic [23:0]         qpress_q;
  logic                softRst_q;
  logic [SETTLE_W-1:0] settleCnt_q;
  logic                partOk_q;
  logic [7:0]          rdByte;
  logic                wrOk;
  logic                clrPress;
  logic                clrTemp;
  logic                clrOver;

  bank_if bus ();

  access_gate u_gate (
    .g (bus.gate)
  );

  slot_scheduler u_sched (
    .mclk     (mclk),
    .rstSyncB (rstSyncB),
    .s        (bus.sched)
  );

  assign bus.addr      = regAddr;
  assign bus.highPower = mode_q[MODE_HP_BIT];
  assign bus.runOn     = mode_q[MODE_RUN_BIT];
  assign bus.tempEn    = mode_q[MODE_TEMP_BIT];
  assign bus.pressEn   = mode_q[MODE_PRESS_BIT];
  assign bus.slotReq   = slotRequest;

  // writes outside the permitted set are dropped without an answer
  assign wrOk     = regWrEn && bus.accessOk;
  assign clrPress = regRdEn && bus.accessOk && regAddr == ADDR_PRESS_TOP;
  assign clrTemp  = regRdEn && bus.accessOk && regAddr == ADDR_TEMP_HIGH;
  assign clrOver  = regRdEn && bus.accessOk && regAddr == ADDR_READY_FLAGS;

  // ---------------------------------------------------------------
  // mode configuration and soft reset
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      mode_q    <= RST_MODE;
      softRst_q <= 1'b0;
    end else if (softRst_q) begin
      mode_q    <= RST_MODE;
      softRst_q <= 1'b0;
    end else if (wrOk && regAddr == ADDR_MODE) begin
      // a fresh start written with a one-shot end is kept
      mode_q    <= regWrData;
      softRst_q <= regWrData[MODE_SRST_BIT];
    end else if (oneShotDone) begin
      mode_q[MODE_RUN_BIT] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // high-power settling window
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      settleCnt_q <= '0;
      settleBusy  <= 1'b0;
    end else if (softRst_q) begin
      settleCnt_q <= '0;
      settleBusy  <= 1'b0;
    end else if (wrOk && regAddr == ADDR_MODE &&
                 regWrData[MODE_HP_BIT] && !mode_q[MODE_HP_BIT]) begin
      // flags the time the host must leave the bus alone
      settleCnt_q <= SETTLE_W'(SETTLE_CYCLES - 1);
      settleBusy  <= 1'b1;
    end else if (settleCnt_q != '0) begin
      settleCnt_q <= settleCnt_q - 1'b1;
    end else begin
      settleBusy  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // thresholds and queue setup
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      loTop_q      <= RST_LO_TOP;
      hiThr_q      <= {RST_HI_BYTE, RST_HI_BYTE, RST_HI_BYTE};
      queueSetup_q <= RST_QUEUE_SETUP;
    end else if (softRst_q) begin
      loTop_q      <= RST_LO_TOP;
      hiThr_q      <= {RST_HI_BYTE, RST_HI_BYTE, RST_HI_BYTE};
      queueSetup_q <= RST_QUEUE_SETUP;
    end else if (wrOk) begin
      if (regAddr == ADDR_LO_TOP) begin
        loTop_q <= regWrData;
      end else if (regAddr == ADDR_HI_BOTTOM) begin
        hiThr_q[7:0] <= regWrData;
      end else if (regAddr == ADDR_HI_MIDDLE) begin
        hiThr_q[15:8] <= regWrData;
      end else if (regAddr == ADDR_HI_TOP) begin
        hiThr_q[23:16] <= regWrData;
      end else if (regAddr == ADDR_QUEUE_SETUP) begin
        queueSetup_q <= regWrData;
      end
    end
  end

  // ---------------------------------------------------------------
  // sample-ready flags: a new sample wins over a clearing read
  // ---------------------------------------------------------------
  always_comb begin
    ready_d = ready_q;
    if (clrPress) begin
      ready_d[READY_PRES_BIT] = 1'b0;
    end
    if (clrTemp) begin
      ready_d[READY_TEMP_BIT] = 1'b0;
    end
    if (clrOver) begin
      ready_d[OVER_PRES_BIT] = 1'b0;
      ready_d[OVER_TEMP_BIT] = 1'b0;
    end
    if (pressValid) begin
      ready_d[READY_PRES_BIT] = 1'b1;
      if (ready_q[READY_PRES_BIT] && !clrPress) begin
        ready_d[OVER_PRES_BIT] = 1'b1;
      end
    end
    if (tempValid) begin
      ready_d[READY_TEMP_BIT] = 1'b1;
      if (ready_q[READY_TEMP_BIT] && !clrTemp) begin
        ready_d[OVER_TEMP_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      ready_q <= RST_READY;
    end else if (softRst_q) begin
      ready_q <= RST_READY;
    end else begin
      ready_q <= ready_d;
    end
  end

  // ---------------------------------------------------------------
  // engine status mirrors
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      fill_q   <= RST_FILL;
      event_q  <= RST_EVENT;
      partOk_q <= 1'b0;
    end else begin
      fill_q   <= queueFlags;
      event_q  <= eventFlags;
      partOk_q <= initDone;
    end
  end

  // ---------------------------------------------------------------
  // result capture
  // ---------------------------------------------------------------
  // the held copy keeps the oldest unread sample; ultra-low power
  // mode has no such buffering and always shows the newest one
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      pressHeld_q   <= {RST_RESULT, RST_RESULT, RST_RESULT};
      pressLatest_q <= {RST_RESULT, RST_RESULT, RST_RESULT};
    end else if (softRst_q) begin
      pressHeld_q   <= {RST_RESULT, RST_RESULT, RST_RESULT};
      pressLatest_q <= {RST_RESULT, RST_RESULT, RST_RESULT};
    end else if (pressValid) begin
      pressLatest_q <= pressSample;
      if (!ready_q[READY_PRES_BIT] || clrPress || ultraLowPower) begin
        pressHeld_q <= pressSample;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      temp_q <= {RST_RESULT, RST_RESULT};
    end else if (softRst_q) begin
      temp_q <= {RST_RESULT, RST_RESULT};
    end else if (tempValid) begin
      temp_q <= tempSample;
    end
  end

  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      qpress_q <= {RST_RESULT, RST_RESULT, RST_RESULT};
    end else if (softRst_q) begin
      qpress_q <= {RST_RESULT, RST_RESULT, RST_RESULT};
    end else if (queuedValid) begin
      qpress_q <= queuedSample;
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  logic [23:0] pressView;
  assign pressView = ultraLowPower ? pressLatest_q : pressHeld_q;

  always_comb begin
    rdByte = 8'h00;
    if (!bus.accessOk) begin
      rdByte = 8'h00;
    end else if (regAddr == ADDR_PART_LOW) begin
      rdByte = partOk_q ? PART_CODE[7:0] : 8'h00;
    end else if (regAddr == ADDR_PART_HIGH) begin
      rdByte = partOk_q ? PART_CODE[15:8] : 8'h00;
    end else if (regAddr == ADDR_SERIAL0) begin
      rdByte = UNIT_SERIAL[7:0];
    end else if (regAddr == ADDR_SERIAL1) begin
      rdByte = UNIT_SERIAL[15:8];
    end else if (regAddr == ADDR_SERIAL2) begin
      rdByte = UNIT_SERIAL[23:16];
    end else if (regAddr == ADDR_SERIAL3) begin
      rdByte = UNIT_SERIAL[31:24];
    end else if (regAddr == ADDR_MODE) begin
      rdByte = mode_q;
    end else if (regAddr == ADDR_LO_TOP) begin
      rdByte = loTop_q;
    end else if (regAddr == ADDR_HI_BOTTOM) begin
      rdByte = hiThr_q[7:0];
    end else if (regAddr == ADDR_HI_MIDDLE) begin
      rdByte = hiThr_q[15:8];
    end else if (regAddr == ADDR_HI_TOP) begin
      rdByte = hiThr_q[23:16];
    end else if (regAddr == ADDR_QUEUE_SETUP) begin
      rdByte = queueSetup_q;
    end else if (regAddr == ADDR_READY_FLAGS) begin
      rdByte = ready_q;
    end else if (regAddr == ADDR_FILL_FLAGS) begin
      rdByte = fill_q;
    end else if (regAddr == ADDR_EVENT_FLAGS) begin
      rdByte = event_q;
    end else if (regAddr == ADDR_PRESS_BOTTOM) begin
      rdByte = pressView[7:0];
    end else if (regAddr == ADDR_PRESS_MIDDLE) begin
      rdByte = pressView[15:8];
    end else if (regAddr == ADDR_PRESS_TOP) begin
      rdByte = pressView[23:16];
    end else if (regAddr == ADDR_TEMP_LOW) begin
      rdByte = temp_q[7:0];
    end else if (regAddr == ADDR_TEMP_HIGH) begin
      rdByte = temp_q[15:8];
    end else if (regAddr == ADDR_QPRESS_BOTTOM) begin
      rdByte = qpress_q[7:0];
    end else if (regAddr == ADDR_QPRESS_MIDDLE) begin
      rdByte = qpress_q[15:8];
    end else if (regAddr == ADDR_QPRESS_TOP) begin
      rdByte = qpress_q[23:16];
    end
  end

  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      regRdData   <= 8'h00;
      regRdValid  <= 1'b0;
      regNextAddr <= 8'h00;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdByte;
      end
      if (regRdEn || regWrEn) begin
        regNextAddr <= bus.nextAddr;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign highPower         = mode_q[MODE_HP_BIT];
  assign pathSelect        = path_t'(mode_q[MODE_PATH_HI:MODE_PATH_LO]);
  assign runEnable         = mode_q[MODE_RUN_BIT];
  assign temperatureEnable = mode_q[MODE_TEMP_BIT];
  assign pressureEnable    = mode_q[MODE_PRESS_BIT];
  assign lowThresholdTop   = loTop_q;
  assign highThreshold     = hiThr_q;
  assign queueSetup        = queueSetup_q;
  assign softResetPulse    = softRst_q;
  assign slotValid         = bus.slotValid;
  assign slotIsTemp        = bus.slotIsTemp;

endmodule : pressure_sensor_register_bank

// ### tb/pressure_bank_props.sv
// concurrent checks on the register bank top ports
`timescale 1ns/10ps
module pressure_bank_props
  import pressure_bank_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  input wire logic [7:0]  regNextAddr,
  // engine side
  input wire logic        oneShotDone,
  input wire logic        highPower,
  input wire path_t       pathSelect,
  input wire logic        runEnable,
  input wire logic [23:0] highThreshold,
  input wire logic [7:0]  lowThresholdTop,
  input wire logic        softResetPulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic modeWr;
  assign modeWr = regWrEn && regAddr == ADDR_MODE && !softResetPulse;
  property p_srst;
    modeWr && regWrData[MODE_SRST_BIT] |=> softResetPulse;
  endproperty
  a_srst: assert property (p_srst) else $error("no reset pulse");
  property p_srst_val;
    softResetPulse |=> highThreshold == 24'hFFFFFF && lowThresholdTop == 8'h00;
  endproperty
  a_srst_val: assert property (p_srst_val) else $error("bad reset");
  property p_wrap;
    regRdEn && regAddr == ADDR_QPRESS_TOP |=> regNextAddr == ADDR_QPRESS_BOTTOM;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_oneshot;
    oneShotDone && !regWrEn |=> !runEnable;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("run kept");
  property p_run;
    modeWr |=> runEnable == $past(regWrData[MODE_RUN_BIT]);
  endproperty
  a_run: assert property (p_run) else $error("run bit wrong");
  property p_path;
    modeWr |=> pathSelect == $past(regWrData[6:5]);
  endproperty
  a_path: assert property (p_path) else $error("path wrong");
  property p_gate_wr;
    !highPower && regWrEn && regAddr == ADDR_HI_MIDDLE && !softResetPulse
      |=> $stable(highThreshold);
  endproperty
  a_gate_wr: assert property (p_gate_wr) else $error("gated write");
  property p_gate_rd;
    !highPower && regRdEn && regAddr == ADDR_HI_MIDDLE |=> regRdData == 8'h00;
  endproperty
  a_gate_rd: assert property (p_gate_rd) else $error("gated read");
endmodule : pressure_bank_props
bind pressure_sensor_register_bank pressure_bank_props u_props (.mclk, .rst_b,
  .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .regNextAddr,
  .oneShotDone, .highPower, .pathSelect, .runEnable, .highThreshold,
  .lowThresholdTop, .softResetPulse);

// ### tb/host_model.sv
// host side model driving the byte register port
`timescale 1ns/10ps
module host_model (
  // clock and read return
  input  wire logic       mclk,
  input  wire logic [7:0] regRdData,
  // byte request
  output logic      [7:0] regAddr = 8'h00,
  output logic      [7:0] regWrData = 8'h00,
  output logic            regWrEn = 1'b0,
  output logic            regRdEn = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge mclk);
    regWrEn = 1'b0;
    regAddr = ~a; // released lines must not keep the old value
    regWrData = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask : rd
endmodule : host_model

// ### tb/testbench.sv
// self-checking bench for the pressure sensor register bank
`timescale 1ns/10ps
module testbench;
  import pressure_bank_pkg::*;
  typedef struct packed {logic w; logic [7:0] a, d, e;} row_t;
  logic        mclk, rst_b = 1'b0, initDone = 1'b0, pressValid = 1'b0;
  logic        oneShotDone = 1'b0, slotRequest = 1'b0, regWrEn, regRdEn;
  logic        highPower, runEnable, softResetPulse, settleBusy;
  logic        slotValid, slotIsTemp, regRdValid, ulp = 1'b0;
  logic [7:0]  regAddr, regWrData, regRdData, regNextAddr, got;
  logic [7:0]  queueFlags = 8'h02, eventFlags = 8'h08;
  logic [23:0] pressSample = 24'hABCDEF, highThreshold;
  path_t       pathSelect;
  int          n_errors = 0, n_checks = 0;
  row_t rows [15] = '{
    '{1'b0,8'h00,8'h00,8'hC3}, '{1'b0,8'h01,8'h00,8'h5A},
    '{1'b1,8'h11,8'h12,8'h00}, '{1'b0,8'h02,8'h00,8'h00},
    '{1'b0,8'h15,8'h00,8'h02}, '{1'b1,8'h06,8'h80,8'h80},
    '{1'b0,8'h11,8'h00,8'hFF}, '{1'b0,8'h0F,8'h00,8'h00},
    '{1'b1,8'h11,8'hA5,8'hA5}, '{1'b0,8'h02,8'h00,8'hCD},
    '{1'b0,8'h05,8'h00,8'h12}, '{1'b1,8'h00,8'hFF,8'hC3},
    '{1'b1,8'h20,8'h55,8'h00}, '{1'b1,8'h06,8'hA0,8'hA0},
    '{1'b1,8'h06,8'hC0,8'hC0}};
  host_model host (.mclk, .regRdData, .regAddr, .regWrData, .regWrEn,
    .regRdEn);
  pressure_sensor_register_bank #(.SETTLE_CYCLES(10)) DUT (.mclk, .rst_b,
    .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .regRdValid,
    .regNextAddr, .initDone, .ultraLowPower(ulp), .pressSample, .pressValid,
    .tempSample(16'h0000), .tempValid(1'b0), .queuedSample(pressSample),
    .queuedValid(pressValid), .oneShotDone, .queueFlags, .eventFlags,
    .slotRequest,
    .highPower, .pathSelect, .runEnable, .temperatureEnable(),
    .pressureEnable(), .lowThresholdTop(), .highThreshold, .queueSetup(),
    .softResetPulse, .settleBusy, .slotValid, .slotIsTemp);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [23:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    initDone = 1'b1;
    repeat (3) @(negedge mclk);
    foreach (rows[i]) begin
      if (rows[i].w) host.wr(rows[i].a, rows[i].d);
      for (int t = 0; settleBusy !== 1'b0; t++) begin
        if (t == 50) begin
          n_errors++;
          tally_and_finish();
        end
        @(negedge mclk);
      end
      host.rd(rows[i].a, got);
      chk("table read", rows[i].e, got);
    end
    host.rd(ADDR_QPRESS_TOP, got);
    chk("next address", ADDR_QPRESS_BOTTOM, regNextAddr);
    chk("read valid", 1'b1, regRdValid);
    pressValid = 1'b1;
    @(negedge mclk);
    pressValid = 1'b0;
    for (int k = 0; k < 3; k++) begin
      host.rd(ADDR_PRESS_BOTTOM + 8'(k), got);
      chk("pressure byte", pressSample[8*k +: 8], got);
      host.rd(ADDR_QPRESS_BOTTOM + 8'(k), got);
      chk("queued byte", pressSample[8*k +: 8], got);
    end
    // two samples with no read between: held view keeps the first
    pressValid = 1'b1;
    @(negedge mclk);
    pressSample = 24'h123456;
    @(negedge mclk);
    pressValid = 1'b0;
    host.rd(ADDR_PRESS_BOTTOM, got);
    chk("held pressure", 8'hEF, got);
    ulp = 1'b1;
    host.rd(ADDR_PRESS_BOTTOM, got);
    chk("latest pressure", 8'h56, got);
    host.wr(ADDR_MODE, 8'h93);
    for (int k = 0; k < 3; k++) begin
      slotRequest = 1'b1;
      @(negedge mclk);
      slotRequest = 1'b0;
      chk("slot grant", 1'b1, slotValid);
      chk("slot kind", k % 2 == 0, slotIsTemp);
      @(negedge mclk);
    end
    oneShotDone = 1'b1;
    @(negedge mclk);
    oneShotDone = 1'b0;
    chk("run bit", 1'b0, runEnable);
    host.wr(ADDR_MODE, 8'h08);
    @(negedge mclk);
    chk("high threshold", 24'hFFFFFF, highThreshold);
    host.rd(ADDR_MODE, got);
    chk("mode after reset", RST_MODE, got);
    tally_and_finish();
  end
endmodule : testbench
